/* rtl/flash_host_pkg.sv */
// constants, types and register map of the flash erase host controller
package flash_host_pkg;

    // ************************************************************
    // clock and pin timing
    // ************************************************************
    localparam int unsigned CLK_NS      = 5;
    localparam int unsigned STROBE_NS   = 35;
    localparam int unsigned RECOVER_NS  = 20;
    localparam int unsigned STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;

    typedef logic [3:0]  cnt_t;
    typedef logic [18:0] faddr_t;
    typedef logic [15:0] fdata_t;
    typedef logic [2:0]  step_t;
    typedef logic [7:0]  off_t;

    localparam cnt_t STROBE_CNT  = cnt_t'(STROBE_CYC);
    localparam cnt_t RECOVER_CNT = cnt_t'(RECOVER_CYC);
    localparam cnt_t CNT_ONE     = 4'h1;
    localparam cnt_t CNT_ZERO    = 4'h0;

    // ************************************************************
    // flash command words (word mode)
    // ************************************************************
    localparam faddr_t UNLOCK_A1       = 19'h0_0555;
    localparam faddr_t UNLOCK_A2       = 19'h0_02AA;
    localparam fdata_t UNLOCK_D1       = 16'h00AA;
    localparam fdata_t UNLOCK_D2       = 16'h0055;
    localparam fdata_t CMD_PROGRAM     = 16'h00A0;
    localparam fdata_t CMD_ERASE_SETUP = 16'h0080;
    localparam fdata_t CMD_CHIP_ERASE  = 16'h0010;
    localparam fdata_t CMD_SECTOR      = 16'h0030;
    localparam fdata_t CMD_SUSPEND     = 16'h00B0;
    localparam fdata_t CMD_RESUME      = 16'h0030;
    localparam fdata_t CMD_RESET       = 16'h00F0;

    // status bit positions in a flash read word
    localparam int unsigned TOGGLE_BIT  = 6;
    localparam int unsigned TIMEOUT_BIT = 5;

    // ************************************************************
    // operations and sequence lengths
    // ************************************************************
    typedef enum logic [2:0] {
        OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE,
        OP_SUSPEND, OP_RESUME, OP_RESET, OP_POLL
    } op_t;

    localparam step_t STEP_FIRST   = 3'h0;
    localparam step_t STEP_ONE     = 3'h1;
    localparam step_t STEP_SETUP   = 3'h2;
    localparam step_t STEP_UNLOCK3 = 3'h3;
    localparam step_t STEP_UNLOCK4 = 3'h4;
    localparam step_t LAST_PROGRAM = 3'h3;
    localparam step_t LAST_ERASE   = 3'h5;
    localparam step_t LAST_POLL    = 3'h2;
    localparam step_t ERASE_WRITES = 3'h6;

    // ************************************************************
    // register map
    // ************************************************************
    localparam off_t REG_CTRL   = 8'h00;
    localparam off_t REG_ADDR   = 8'h04;
    localparam off_t REG_DATA   = 8'h08;
    localparam off_t REG_STATUS = 8'h0C;

    localparam int unsigned ST_BUSY    = 0;
    localparam int unsigned ST_TOGGLE  = 1;
    localparam int unsigned ST_TIMEOUT = 2;
    localparam int unsigned ST_READY   = 3;

endpackage

/* rtl/flash_cycle_if.sv */
// one flash bus cycle request between sequencer and pin engine
`timescale 1ns/100ps
interface flash_cycle_if;
    logic                   req;
    logic                   wr;
    flash_host_pkg::faddr_t addr;
    flash_host_pkg::fdata_t wdata;
    flash_host_pkg::fdata_t rdata;
    logic                   done;

    modport ctrl (output req, output wr, output addr, output wdata,
                  input rdata, input done);
    modport eng  (input req, input wr, input addr, input wdata,
                  output rdata, output done);
endinterface

/* rtl/flash_cycle_engine.sv */
// pin engine: one timed write or read cycle on the flash pins
`timescale 1ns/100ps
module flash_cycle_engine (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // request from sequencer
    flash_cycle_if.eng                  cyc,
    // flash pins
    output logic                        ce_n,
    output logic                        we_n,
    output logic                        oe_n,
    output flash_host_pkg::faddr_t      addr,
    output flash_host_pkg::fdata_t      dq_out,
    output logic                        dq_oe,
    input  wire flash_host_pkg::fdata_t dq_in
);

    typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_RECOVER} est_t;

    typedef struct packed {
        est_t                   st;
        flash_host_pkg::cnt_t   cnt;
        logic                   ce_n;
        logic                   we_n;
        logic                   oe_n;
        logic                   dq_oe;
        flash_host_pkg::faddr_t addr;
        flash_host_pkg::fdata_t dq;
        flash_host_pkg::fdata_t rdata;
        logic                   done;
    } eng_t;

    eng_t q;
    eng_t d;

    // ************************************************************
    // cycle timing
    // ************************************************************
    // address setup, strobe low for the strobe time, then recovery
    always_comb
    begin
        d      = q;
        d.done = 1'b0;
        unique case (q.st)
            E_IDLE:
            begin
                // done_q blocks a restart on the request still held
                if (cyc.req && !q.done)
                begin
                    d.st    = E_SETUP;
                    d.ce_n  = 1'b0;
                    d.addr  = cyc.addr;
                    d.dq    = cyc.wdata;
                    d.dq_oe = cyc.wr;
                end
            end
            E_SETUP:
            begin
                d.st   = E_STROBE;
                d.cnt  = flash_host_pkg::STROBE_CNT;
                d.we_n = !cyc.wr;
                d.oe_n = cyc.wr;
            end
            E_STROBE:
            begin
                d.cnt = q.cnt - flash_host_pkg::CNT_ONE;
                if (q.cnt == flash_host_pkg::CNT_ONE)
                begin
                    d.st    = E_RECOVER;
                    d.cnt   = flash_host_pkg::RECOVER_CNT;
                    d.we_n  = 1'b1;
                    d.oe_n  = 1'b1;
                    d.rdata = dq_in;
                end
            end
            E_RECOVER:
            begin
                d.cnt = q.cnt - flash_host_pkg::CNT_ONE;
                if (q.cnt == flash_host_pkg::CNT_ONE)
                begin
                    d.st    = E_IDLE;
                    d.ce_n  = 1'b1;
                    d.dq_oe = 1'b0;
                    d.done  = 1'b1;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            q      <= '0;
            q.st   <= E_IDLE;
            q.ce_n <= 1'b1;
            q.we_n <= 1'b1;
            q.oe_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // pins and answer straight from the state register
    assign ce_n      = q.ce_n;
    assign we_n      = q.we_n;
    assign oe_n      = q.oe_n;
    assign addr      = q.addr;
    assign dq_out    = q.dq;
    assign dq_oe     = q.dq_oe;
    assign cyc.rdata = q.rdata;
    assign cyc.done  = q.done;

    // ************************************************************
    // checks
    // ************************************************************
    sequence strobe_low_s;
        (!q.we_n || !q.oe_n)[*7];
    endsequence

    strobe_width_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (q.st == E_SETUP) |=> strobe_low_s ##1 (q.we_n && q.oe_n))
        else $error("strobe width wrong");

    data_driven_write_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $fell(q.we_n) |-> (q.dq_oe && !q.ce_n && q.oe_n))
        else $error("write strobe without driven data");

endmodule

/* rtl/flash_erase_host.sv */
// flash erase host: apb registers, command sequences and status polling
//
// Overview of operation
// - chip erase: six writes, ending 10
// - sector erase: six writes, last at sector
// - poll inside the target sector
// - reread after poll for full data
// - command codes 80 10 30 B0 30
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module flash_erase_host (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // flash pins
    output logic                        flash_ce_n,
    output logic                        flash_we_n,
    output logic                        flash_oe_n,
    output flash_host_pkg::faddr_t      flash_addr,
    output flash_host_pkg::fdata_t      flash_dq_out,
    output logic                        flash_dq_oe,
    input  wire flash_host_pkg::fdata_t flash_dq_in,
    input  wire logic                   ready_busy_out_n
);

    typedef enum logic {S_IDLE, S_ISSUE} sst_t;

    typedef struct packed {
        sst_t                   st;
        flash_host_pkg::op_t    op;
        flash_host_pkg::step_t  step;
        flash_host_pkg::faddr_t addr;
        flash_host_pkg::fdata_t wdata;
        flash_host_pkg::fdata_t rdata;
        flash_host_pkg::fdata_t prev;
        logic                   toggled;
        logic                   timeout;
        logic                   rb;
        logic                   req;
        logic                   wr;
        flash_host_pkg::faddr_t eaddr;
        flash_host_pkg::fdata_t edata;
        flash_host_pkg::step_t  wcnt;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } host_t;

    host_t q;
    host_t d;

    flash_cycle_if cyc ();

    // ************************************************************
    // command sequences
    // ************************************************************
    // bus cycle of a given step: {write, address, data}
    function automatic logic [35:0] step_of(input flash_host_pkg::op_t op,
                                            input flash_host_pkg::step_t s,
                                            input flash_host_pkg::faddr_t a,
                                            input flash_host_pkg::fdata_t v);
        logic                   w;
        flash_host_pkg::faddr_t sa;
        flash_host_pkg::fdata_t sd;
        w  = 1'b1;
        sa = a;
        sd = v;
        unique case (op)
            flash_host_pkg::OP_READ, flash_host_pkg::OP_POLL:
                w = 1'b0;
            flash_host_pkg::OP_SUSPEND:
                sd = flash_host_pkg::CMD_SUSPEND;
            flash_host_pkg::OP_RESUME:
                sd = flash_host_pkg::CMD_RESUME;
            flash_host_pkg::OP_RESET:
                sd = flash_host_pkg::CMD_RESET;
            default:
            begin
                // erase: unlock, setup, unlock, command; program: unlock, A0, data
                if (s == flash_host_pkg::STEP_FIRST || s == flash_host_pkg::STEP_UNLOCK3)
                begin
                    if (op != flash_host_pkg::OP_PROGRAM || s == flash_host_pkg::STEP_FIRST)
                    begin
                        sa = flash_host_pkg::UNLOCK_A1;
                        sd = flash_host_pkg::UNLOCK_D1;
                    end
                end
                else if (s == flash_host_pkg::STEP_ONE || s == flash_host_pkg::STEP_UNLOCK4)
                begin
                    sa = flash_host_pkg::UNLOCK_A2;
                    sd = flash_host_pkg::UNLOCK_D2;
                end
                else if (s == flash_host_pkg::STEP_SETUP)
                begin
                    sa = flash_host_pkg::UNLOCK_A1;
                    sd = (op == flash_host_pkg::OP_PROGRAM) ? flash_host_pkg::CMD_PROGRAM
                                                            : flash_host_pkg::CMD_ERASE_SETUP;
                end
                else if (op == flash_host_pkg::OP_CHIP_ERASE)
                begin
                    sa = flash_host_pkg::UNLOCK_A1;
                    sd = flash_host_pkg::CMD_CHIP_ERASE;
                end
                else
                begin
                    sd = flash_host_pkg::CMD_SECTOR;
                end
            end
        endcase
        return {w, sa, sd};
    endfunction

    // index of the last step of an operation
    function automatic flash_host_pkg::step_t last_of(input flash_host_pkg::op_t op);
        unique case (op)
            flash_host_pkg::OP_PROGRAM:      return flash_host_pkg::LAST_PROGRAM;
            flash_host_pkg::OP_CHIP_ERASE,
            flash_host_pkg::OP_SECTOR_ERASE: return flash_host_pkg::LAST_ERASE;
            flash_host_pkg::OP_POLL:         return flash_host_pkg::LAST_POLL;
            default:                         return flash_host_pkg::STEP_FIRST;
        endcase
    endfunction

    logic        apb_wr;
    logic        apb_setup;
    logic        finish;
    logic        toggle_seen;
    logic [35:0] nxt;
    flash_host_pkg::op_t new_op;

    assign apb_wr      = psel && penable && pwrite && q.pready;
    assign apb_setup   = psel && !penable;
    assign new_op      = flash_host_pkg::op_t'(pwdata[2:0]);
    assign toggle_seen = cyc.rdata[flash_host_pkg::TOGGLE_BIT]
                         != q.prev[flash_host_pkg::TOGGLE_BIT];
    // a poll that toggles ends after two reads
    assign finish      = (q.step == last_of(q.op))
                         || (q.op == flash_host_pkg::OP_POLL
                             && q.step == flash_host_pkg::STEP_ONE && toggle_seen);

    // ************************************************************
    // sequencer and apb registers
    // ************************************************************
    always_comb
    begin
        d         = q;
        nxt       = '0;
        d.rb      = ready_busy_out_n;
        d.pready  = apb_setup;
        d.pslverr = 1'b0;
        // register write at the access edge; ctrl ignored while busy
        if (apb_wr)
        begin
            unique case (paddr)
                flash_host_pkg::REG_ADDR: d.addr  = pwdata[18:0];
                flash_host_pkg::REG_DATA: d.wdata = pwdata[15:0];
                flash_host_pkg::REG_CTRL:
                begin
                    if (q.st == S_IDLE)
                    begin
                        nxt     = step_of(new_op, flash_host_pkg::STEP_FIRST, q.addr, q.wdata);
                        d.op    = new_op;
                        d.step  = flash_host_pkg::STEP_FIRST;
                        d.st    = S_ISSUE;
                        d.req   = 1'b1;
                        d.wr    = nxt[35];
                        d.eaddr = nxt[34:16];
                        d.edata = nxt[15:0];
                        d.wcnt  = flash_host_pkg::STEP_FIRST;
                    end
                end
                default: ;
            endcase
        end
        // read data and error prepared in the setup cycle
        if (apb_setup)
        begin
            d.prdata = '0;
            unique case (paddr)
                flash_host_pkg::REG_CTRL:   d.prdata[2:0]  = q.op;
                flash_host_pkg::REG_ADDR:   d.prdata[18:0] = q.addr;
                flash_host_pkg::REG_DATA:   d.prdata[15:0] = q.rdata;
                flash_host_pkg::REG_STATUS:
                begin
                    d.prdata[flash_host_pkg::ST_BUSY]    = (q.st == S_ISSUE);
                    d.prdata[flash_host_pkg::ST_TOGGLE]  = q.toggled;
                    d.prdata[flash_host_pkg::ST_TIMEOUT] = q.timeout;
                    d.prdata[flash_host_pkg::ST_READY]   = q.rb;
                end
                default: d.pslverr = 1'b1;
            endcase
        end
        // step completion
        if (q.st == S_ISSUE && cyc.done)
        begin
            if (q.wr)
                d.wcnt = q.wcnt + flash_host_pkg::STEP_ONE;
            else
            begin
                d.rdata = cyc.rdata;
                d.prev  = cyc.rdata;
            end
            if (q.op == flash_host_pkg::OP_POLL && q.step == flash_host_pkg::STEP_ONE)
            begin
                d.toggled = toggle_seen;
                d.timeout = toggle_seen && cyc.rdata[flash_host_pkg::TIMEOUT_BIT];
            end
            if (finish)
            begin
                d.st  = S_IDLE;
                d.req = 1'b0;
            end
            else
            begin
                // further read after a settled poll gives full data
                d.step  = q.step + flash_host_pkg::STEP_ONE;
                nxt     = step_of(q.op, d.step, q.addr, q.wdata);
                d.wr    = nxt[35];
                d.eaddr = nxt[34:16];
                d.edata = nxt[15:0];
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            q    <= '0;
            q.st <= S_IDLE;
            q.rb <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // request to the pin engine
    assign cyc.req   = q.req;
    assign cyc.wr    = q.wr;
    assign cyc.addr  = q.eaddr;
    assign cyc.wdata = q.edata;

    assign prdata  = q.prdata;
    assign pready  = q.pready;
    assign pslverr = q.pslverr;

    // ************************************************************
    // pin engine
    // ************************************************************
    flash_cycle_engine u_engine (
        .sys_clk (sys_clk),
        .rst     (rst),
        .cyc     (cyc.eng),
        .ce_n    (flash_ce_n),
        .we_n    (flash_we_n),
        .oe_n    (flash_oe_n),
        .addr    (flash_addr),
        .dq_out  (flash_dq_out),
        .dq_oe   (flash_dq_oe),
        .dq_in   (flash_dq_in)
    );

    // ************************************************************
    // checks
    // ************************************************************
    sequence cycle_done_s;
        cyc.req ##[1:40] cyc.done;
    endsequence

    logic step_end;
    assign step_end = q.st == S_ISSUE && cyc.done && finish;

    chip_six_writes_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (step_end && q.op == flash_host_pkg::OP_CHIP_ERASE)
        |-> (q.wcnt == flash_host_pkg::LAST_ERASE))
        else $error("chip erase did not issue six writes");

    sector_last_addr_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (q.req && q.op == flash_host_pkg::OP_SECTOR_ERASE && q.step == flash_host_pkg::LAST_ERASE)
        |-> (q.eaddr == q.addr && q.edata == flash_host_pkg::CMD_SECTOR))
        else $error("sector erase final write wrong");

    setup_code_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (q.req && q.op == flash_host_pkg::OP_CHIP_ERASE && q.step == flash_host_pkg::STEP_SETUP)
        |-> (q.edata == flash_host_pkg::CMD_ERASE_SETUP && q.wr))
        else $error("erase setup code wrong");

    poll_in_sector_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (q.req && q.op == flash_host_pkg::OP_POLL) |-> (!q.wr && q.eaddr == q.addr))
        else $error("poll read outside target address");

    settled_reread_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (step_end && q.op == flash_host_pkg::OP_POLL && !toggle_seen)
        |-> (q.step == flash_host_pkg::LAST_POLL))
        else $error("settled poll ended without extra read");

    start_runs_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (apb_wr && paddr == flash_host_pkg::REG_CTRL && q.st == S_IDLE)
        |=> cycle_done_s)
        else $error("started operation issued no bus cycle");

    unmapped_err_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (apb_setup && paddr > flash_host_pkg::REG_STATUS) |=> (pready && pslverr))
        else $error("unmapped access not refused");

endmodule

/* test/flash_dev_model.sv */
// behavioural flash device: erase and program decoder with status reads
`timescale 1ns/100ps
module flash_dev_model #(
    parameter int         PROG_CYC  = 100,
    parameter int         ERASE_CYC = 300,
    parameter int         PROT_CYC  = 20,
    // protected sector number, arbitrary
    parameter logic [6:0] PROT_SEC  = 7'h7F
) (
    // counter clock
    input  wire logic                   clk,
    // flash pins
    input  wire logic                   ce_n,
    input  wire logic                   we_n,
    input  wire logic                   oe_n,
    input  wire flash_host_pkg::faddr_t addr,
    input  wire flash_host_pkg::fdata_t din,
    output flash_host_pkg::fdata_t      dout,
    output logic                        ready_busy_out_n
);
    int                     cnt  = 0;
    int                     pcnt = 0;
    int                     step = 0;
    logic                   sect = 1'b0;
    logic                   susp = 1'b0;
    logic                   poll = 1'b0;
    logic                   tog  = 1'b0;
    logic [6:0]             sec_q = 7'h00;
    flash_host_pkg::fdata_t mem [16] = '{default: 16'h0000};
    flash_host_pkg::fdata_t last_q = 16'h0000;
    wire                    prot = addr[18:12] == PROT_SEC;
    wire                    act  = (cnt > 0 && !susp) || pcnt > 0;
    wire                    stat = act || (susp && addr[18:12] == sec_q);
    wire                    bit7 = pcnt > 0 ? poll : susp;
    // status word (timeout bit low, no overrun) or array data
    wire flash_host_pkg::fdata_t val = stat ? {8'h00, bit7, tog, 1'b0, 5'h00}
                                            : mem[addr[3:0]];
    // released bus shows inverse of last
    assign dout = (!ce_n && !oe_n) ? val : ~last_q;
    assign ready_busy_out_n = !act;
    // embedded duration counters, erase frozen while suspended
    always @(posedge clk)
    begin
        if (cnt > 0 && !susp) cnt <= cnt - 1;
        if (pcnt > 0) pcnt <= pcnt - 1;
    end
    // each read flips the toggle bit while busy
    always @(posedge oe_n)
    begin
        if (!ce_n && act) tog = ~tog;
        last_q = val;
    end
    // command decoder
    always @(posedge we_n)
        if (!ce_n)
        begin
            if (act)
            begin
                if (sect && pcnt == 0 && din == flash_host_pkg::CMD_SUSPEND)
                    susp = 1'b1;
            end
            else if (susp && step == 0 && din == flash_host_pkg::CMD_RESUME) susp = 1'b0;
            else case (step)
                0, 3: step = (addr == flash_host_pkg::UNLOCK_A1
                              && din == flash_host_pkg::UNLOCK_D1) ? step + 1 : 0;
                1, 4: step = (addr == flash_host_pkg::UNLOCK_A2
                              && din == flash_host_pkg::UNLOCK_D2) ? step + 1 : 0;
                2: step = din == flash_host_pkg::CMD_ERASE_SETUP ? 3
                        : (din == flash_host_pkg::CMD_PROGRAM ? 6 : 0);
                5:
                begin
                    step = 0;
                    if (din == flash_host_pkg::CMD_CHIP_ERASE || din == flash_host_pkg::CMD_SECTOR)
                    begin
                        sect  = din == flash_host_pkg::CMD_SECTOR;
                        sec_q = addr[18:12];
                        poll  = 1'b0;
                        // protected target only toggles a while
                        if (sect && prot) cnt <= PROT_CYC;
                        else
                        begin
                            cnt <= ERASE_CYC;
                            mem = '{default: 16'hFFFF};
                        end
                    end
                end
                default:
                begin
                    step = 0;
                    if (!prot) mem[addr[3:0]] = din;
                    poll = ~din[7];
                    pcnt <= prot ? PROT_CYC : PROG_CYC;
                end
            endcase
        end
endmodule

/* test/tb_flash_erase_host.sv */
// self-checking bench for the flash erase host controller
`timescale 1ns/100ps
module tb_flash_erase_host;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe, ready_busy_out_n;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        err;
    flash_host_pkg::faddr_t flash_addr;
    flash_host_pkg::fdata_t flash_dq_out, flash_dq_in;
    int mismatches = 0, num_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    flash_erase_host DUT (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_addr,
        .flash_dq_out, .flash_dq_oe, .flash_dq_in, .ready_busy_out_n);
    flash_dev_model dev (.clk(sys_clk), .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
        .addr(flash_addr), .din(flash_dq_out), .dout(flash_dq_in), .ready_busy_out_n);
    // verdict and end of run
    task summarize;
        if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // compare one word
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, result in rd and err
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin mismatches++; summarize(); end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // start an operation and wait until idle
    task run(input logic [2:0] op);
        int n;
        apb(1'b1, flash_host_pkg::REG_CTRL, {29'h0000_0000, op});
        for (n = 0; n < 400; n++)
        begin
            apb(1'b0, flash_host_pkg::REG_STATUS, 32'h0000_0000);
            if (rd[0] === 1'b0) break;
        end
        if (n == 400) begin mismatches++; summarize(); end
    endtask
    // poll until the toggle bit stops
    task settle;
        int n;
        for (n = 0; n < 20; n++)
        begin
            run(3'h7);
            if (rd[1] === 1'b0) break;
        end
        if (n == 20) begin mismatches++; summarize(); end
    endtask
    // main sequence
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, flash_host_pkg::REG_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0008);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        run(3'h6);
        chk(rd, 32'h0000_0008);
        apb(1'b1, flash_host_pkg::REG_ADDR, 32'h0000_0003);
        apb(1'b1, flash_host_pkg::REG_DATA, 32'h0000_1234);
        run(3'h1);
        run(3'h7);
        chk(rd, 32'h0000_0002);
        settle();
        apb(1'b0, flash_host_pkg::REG_DATA, 32'h0000_0000);
        chk(rd, 32'h0000_1234);
        run(3'h2);
        run(3'h4);
        chk(rd, 32'h0000_0000);
        settle();
        apb(1'b0, flash_host_pkg::REG_DATA, 32'h0000_0000);
        chk(rd, 32'h0000_FFFF);
        apb(1'b1, flash_host_pkg::REG_ADDR, 32'h0001_0000);
        run(3'h3);
        run(3'h4);
        chk(rd, 32'h0000_0008);
        run(3'h0);
        apb(1'b0, flash_host_pkg::REG_DATA, 32'h0000_0000);
        chk(rd & 32'h0000_0080, 32'h0000_0080);
        apb(1'b1, flash_host_pkg::REG_ADDR, 32'h0000_0005);
        run(3'h1);
        run(3'h7);
        chk(rd, 32'h0000_0002);
        settle();
        apb(1'b0, flash_host_pkg::REG_DATA, 32'h0000_0000);
        chk(rd, 32'h0000_1234);
        apb(1'b1, flash_host_pkg::REG_ADDR, 32'h0001_0000);
        run(3'h5);
        chk(rd, 32'h0000_0000);
        settle();
        apb(1'b0, flash_host_pkg::REG_DATA, 32'h0000_0000);
        chk(rd, 32'h0000_FFFF);
        summarize();
    end
endmodule
